// *** cpm_board_clk.sv ***
// Board-side clock sources facing the pin mux: transmit, PLL and receive clocks.
// Assumes one system clock; sources change just after its rising edge.
`timescale 1ns/1ps
module cpm_board_clk (
  input  wire logic clk_i,
  input  wire logic srst_i,
  output logic      tx_clk_o,
  output logic      pll_clk_o,
  output logic      rx_clk_o
);
  logic [7:0] cnt_reg;

  // Unequal periods so a wrong source selection shows up
  always_ff @(posedge clk_i) begin
    cnt_reg   <= srst_i ? 8'h00 : cnt_reg + 8'h01;
    tx_clk_o  <= srst_i ? 1'b0 : (cnt_reg % 3 == 0) ^ tx_clk_o;
    pll_clk_o <= srst_i ? 1'b0 : cnt_reg[1];
    rx_clk_o  <= srst_i ? 1'b0 : (cnt_reg % 5 == 0) ^ rx_clk_o;
  end
endmodule // cpm_board_clk

// *** cpm_clk_if.sv ***
// Interface carrying transmit clock selection between the pin mux and its helpers.
// Assumes all members are sampled by the single system clock.
`timescale 1ns/1ps
interface cpm_clk_if;
  logic [1:0] src_sel;
  logic       tx_clk_in;
  logic       pll_clk;
  logic       rx_clk;
  logic       mclk_scaled;
  logic       tx_clk;

  modport ctl (output src_sel, tx_clk_in, pll_clk, rx_clk, input tx_clk);
  modport div (output mclk_scaled);
  modport mux (input src_sel, tx_clk_in, pll_clk, rx_clk, mclk_scaled, output tx_clk);
endinterface // cpm_clk_if

// *** cpm_mclk_div.sv ***
// Divider making the scaled master clock as a registered square wave.
// Assumes a synchronous active-high reset.
`timescale 1ns/1ps
module cpm_mclk_div (
  input  wire logic clk_i,
  input  wire logic srst_i,
  cpm_clk_if.div    ck
);
  import cpm_pkg::*;

  logic [DIV_W-1:0] cnt_reg;
  logic             out_reg;
  logic             tick;

  // Enable pulse at end of each half period
  assign tick = (cnt_reg == MCLK_DIV_LAST);

  // Half period counter and toggle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else if (tick) begin
      cnt_reg <= '0;
      out_reg <= ~out_reg;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign ck.mclk_scaled = out_reg;

  a_div_toggle: assert property (@(posedge clk_i) disable iff (srst_i)
    $changed(out_reg) |-> $past(cnt_reg) == MCLK_DIV_LAST)
    else $error("scaled clock toggled off count");
endmodule // cpm_mclk_div

// *** cpm_pin_mux.sv ***
// Top of the control-mode pin multiplexer with transmit clock selection.
// Assumes pins are synchronous to MCLK_I and an AXI4-Lite master on the bus.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module cpm_pin_mux (
  input  wire logic                       MCLK_I,
  input  wire logic                       SRST_I,
  // Register bus
  input  wire logic [cpm_pkg::AXI_AW-1:0] S_AXI_AWADDR_I,
  input  wire logic                       S_AXI_AWVALID_I,
  output logic                            S_AXI_AWREADY_O,
  input  wire logic [31:0]                S_AXI_WDATA_I,
  input  wire logic [3:0]                 S_AXI_WSTRB_I,
  input  wire logic                       S_AXI_WVALID_I,
  output logic                            S_AXI_WREADY_O,
  output logic [1:0]                      S_AXI_BRESP_O,
  output logic                            S_AXI_BVALID_O,
  input  wire logic                       S_AXI_BREADY_I,
  input  wire logic [cpm_pkg::AXI_AW-1:0] S_AXI_ARADDR_I,
  input  wire logic                       S_AXI_ARVALID_I,
  output logic                            S_AXI_ARREADY_O,
  output logic [31:0]                     S_AXI_RDATA_O,
  output logic [1:0]                      S_AXI_RRESP_O,
  output logic                            S_AXI_RVALID_O,
  input  wire logic                       S_AXI_RREADY_I,
  // Shared control pins
  input  wire logic                       CTRL_MODE_SEL_B0_I,
  input  wire logic                       CTRL_MODE_SEL_B1_I,
  input  wire logic                       IRQ_N_I,
  output logic                            IRQ_N_O,
  output logic                            IRQ_N_OE_O,
  input  wire logic                       BUS_STYLE_SEL_I,
  input  wire logic                       CS_N_I,
  input  wire logic                       RD_N_I,
  input  wire logic                       WR_N_I,
  input  wire logic                       BUS_BIT0_I,
  output logic                            BUS_BIT0_O,
  output logic                            BUS_BIT0_OE_O,
  input  wire logic                       BUS_BIT1_I,
  output logic                            BUS_BIT1_O,
  output logic                            BUS_BIT1_OE_O,
  input  wire logic                       TX_MODE_SEL_B2_I,
  input  wire logic                       TX_MODE_SEL_B1_I,
  input  wire logic                       TX_CLK_SRC_SEL_B1_I,
  // Host port side toward the core
  input  wire logic                       IRQ_REQ_I,
  input  wire logic [1:0]                 PAR_AD_DOUT_I,
  input  wire logic                       PAR_AD_OE_I,
  input  wire logic                       SER_MISO_I,
  output logic                            MODE_PAR_O,
  output logic                            MODE_SER_O,
  output logic                            MODE_HW_O,
  output logic                            HOST_CS_N_O,
  output logic                            HOST_RD_N_O,
  output logic                            HOST_WR_N_O,
  output logic                            HOST_BUS_STYLE_O,
  output logic [1:0]                      HOST_AD_O,
  output logic                            HOST_MOSI_O,
  // Function controls toward the core
  output logic                            JITTER_ATT_CLK_SEL_B0_O,
  output logic                            LINE_CODE_EN_O,
  output logic                            REMOTE_LOOPBACK_EN_O,
  output logic [1:0]                      RX_MODE_SEL_B3_B2_O,
  output logic [2:0]                      TX_MODE_SEL_B3_B1_O,
  output logic                            JIT_ATT_EN_O,
  // Transmit clocks
  input  wire logic                       TX_CLK_IN_I,
  input  wire logic                       PLL_CLK_I,
  input  wire logic                       RX_CLK_I,
  output logic                            PLL_IN_O,
  output logic                            TX_CLK_O,
  output logic                            PLL_OUT_O
);
  import cpm_pkg::*;

  cpm_clk_if ck ();

  cpm_mode_e   mode_reg, mode_next;
  logic [31:0] ctrl_reg;
  logic        irq_oe_reg, irq_oe_next;
  logic        cs_n_reg, cs_n_next, rd_n_reg, rd_n_next, wr_n_reg, wr_n_next;
  logic        bsty_reg, bsty_next, mosi_reg, mosi_next;
  logic [1:0]  ad_reg, ad_next;
  logic        b0_o_reg, b0_o_next, b0_oe_reg, b0_oe_next;
  logic        b1_o_reg, b1_o_next, b1_oe_reg, b1_oe_next;
  logic        jit_reg, jit_next, lce_reg, lce_next, rlp_reg, rlp_next;
  logic [1:0]  rxm_reg, rxm_next, tcs_reg, tcs_next;
  logic [2:0]  txm_reg, txm_next;
  logic        jae_reg, jae_next, pll_in_reg, pll_in_next;
  logic        aw_hold, w_hold;
  logic [7:0]  waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, wmask, stat_word;

  // Mode select decode
  always_comb begin
    case ({CTRL_MODE_SEL_B1_I, CTRL_MODE_SEL_B0_I})
      SEL_PAR: mode_next = MODE_PAR;
      SEL_SER: mode_next = MODE_SER;
      default: mode_next = MODE_HW;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) mode_reg <= MODE_PAR;
    else        mode_reg <= mode_next;
  end

  // Shared pin function selection by mode
  always_comb begin
    irq_oe_next = 1'b0;
    cs_n_next   = 1'b1;
    rd_n_next   = 1'b1;
    wr_n_next   = 1'b1;
    bsty_next   = 1'b0;
    ad_next     = 2'b00;
    mosi_next   = 1'b0;
    b0_o_next   = 1'b0;
    b0_oe_next  = 1'b0;
    b1_o_next   = 1'b0;
    b1_oe_next  = 1'b0;
    jit_next    = ctrl_reg[CTRL_JIT];
    lce_next    = ctrl_reg[CTRL_LCE];
    rlp_next    = ctrl_reg[CTRL_RLP];
    rxm_next    = ctrl_reg[CTRL_RXM +: 2];
    txm_next    = ctrl_reg[CTRL_TXM +: 3];
    tcs_next    = ctrl_reg[CTRL_TCS +: 2];
    jae_next    = ctrl_reg[CTRL_JAE];
    pll_in_next = ctrl_reg[CTRL_PSRC] ? RX_CLK_I : TX_CLK_IN_I;
    case (mode_reg)
      MODE_PAR: begin
        irq_oe_next = IRQ_REQ_I;
        cs_n_next   = CS_N_I;
        rd_n_next   = RD_N_I;
        wr_n_next   = WR_N_I;
        bsty_next   = BUS_STYLE_SEL_I;
        ad_next     = {BUS_BIT1_I, BUS_BIT0_I};
        b0_o_next   = PAR_AD_DOUT_I[0];
        b0_oe_next  = PAR_AD_OE_I;
        b1_o_next   = PAR_AD_DOUT_I[1];
        b1_oe_next  = PAR_AD_OE_I;
      end
      MODE_SER: begin
        irq_oe_next = IRQ_REQ_I;
        cs_n_next   = CS_N_I;
        mosi_next   = BUS_BIT1_I;
        b0_o_next   = SER_MISO_I;
        b0_oe_next  = ~CS_N_I;
      end
      MODE_HW: begin
        jit_next    = IRQ_N_I;
        lce_next    = BUS_STYLE_SEL_I;
        rlp_next    = CS_N_I;
        rxm_next    = {BUS_BIT1_I, RD_N_I};
        txm_next    = {WR_N_I, TX_MODE_SEL_B2_I, TX_MODE_SEL_B1_I};
        tcs_next    = {TX_CLK_SRC_SEL_B1_I, BUS_BIT0_I};
        jae_next    = HW_JIT_ATT_EN;
        pll_in_next = TX_CLK_IN_I;
      end
      default: begin
        irq_oe_next = 1'b0;
      end
    endcase
  end

  // Pin and function registers
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      irq_oe_reg <= 1'b0;
      cs_n_reg   <= 1'b1;
      rd_n_reg   <= 1'b1;
      wr_n_reg   <= 1'b1;
      bsty_reg   <= 1'b0;
      ad_reg     <= 2'b00;
      mosi_reg   <= 1'b0;
      b0_o_reg   <= 1'b0;
      b0_oe_reg  <= 1'b0;
      b1_o_reg   <= 1'b0;
      b1_oe_reg  <= 1'b0;
      jit_reg    <= 1'b0;
      lce_reg    <= 1'b0;
      rlp_reg    <= 1'b0;
      rxm_reg    <= 2'b00;
      txm_reg    <= 3'b000;
      tcs_reg    <= TCS_TXCLK;
      jae_reg    <= HW_JIT_ATT_EN;
      pll_in_reg <= 1'b0;
    end else begin
      irq_oe_reg <= irq_oe_next;
      cs_n_reg   <= cs_n_next;
      rd_n_reg   <= rd_n_next;
      wr_n_reg   <= wr_n_next;
      bsty_reg   <= bsty_next;
      ad_reg     <= ad_next;
      mosi_reg   <= mosi_next;
      b0_o_reg   <= b0_o_next;
      b0_oe_reg  <= b0_oe_next;
      b1_o_reg   <= b1_o_next;
      b1_oe_reg  <= b1_oe_next;
      jit_reg    <= jit_next;
      lce_reg    <= lce_next;
      rlp_reg    <= rlp_next;
      rxm_reg    <= rxm_next;
      txm_reg    <= txm_next;
      tcs_reg    <= tcs_next;
      jae_reg    <= jae_next;
      pll_in_reg <= pll_in_next;
    end
  end

  // Clock selection helpers
  assign ck.src_sel   = tcs_reg;
  assign ck.tx_clk_in = TX_CLK_IN_I;
  assign ck.pll_clk   = PLL_CLK_I;
  assign ck.rx_clk    = RX_CLK_I;

  cpm_mclk_div u_div (
    .clk_i  (MCLK_I),
    .srst_i (SRST_I),
    .ck     (ck.div)
  );

  cpm_txclk_mux u_mux (
    .clk_i  (MCLK_I),
    .srst_i (SRST_I),
    .ck     (ck.mux)
  );

  // Register bus write side
  always_comb begin
    wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      aw_hold     <= 1'b0;
      w_hold      <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      waddr_reg   <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      ctrl_reg    <= CTRL_RESET;
    end else begin
      if (S_AXI_AWVALID_I && awready_reg) begin
        aw_hold     <= 1'b1;
        awready_reg <= 1'b0;
        waddr_reg   <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && wready_reg) begin
        w_hold     <= 1'b1;
        wready_reg <= 1'b0;
        wdata_reg  <= S_AXI_WDATA_I;
        wstrb_reg  <= S_AXI_WSTRB_I;
      end
      if (aw_hold && w_hold && !bvalid_reg) begin
        aw_hold    <= 1'b0;
        w_hold     <= 1'b0;
        bvalid_reg <= 1'b1;
        if (waddr_reg == ADDR_CTRL) begin
          ctrl_reg  <= ((ctrl_reg & ~wmask) | (wdata_reg & wmask)) & CTRL_MASK;
          bresp_reg <= RESP_OKAY;
        end else if (waddr_reg == ADDR_STAT) begin
          bresp_reg <= RESP_OKAY;
        end else begin
          bresp_reg <= RESP_SLVERR;
        end
      end
      if (bvalid_reg && S_AXI_BREADY_I) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Status word shows live mode and clock selection
  always_comb begin
    stat_word = '0;
    stat_word[STAT_MODE +: 3] = mode_reg;
    stat_word[STAT_TCS +: 2]  = tcs_reg;
    stat_word[STAT_TXCK]      = ck.tx_clk;
  end

  // Register bus read side
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else if (S_AXI_ARVALID_I && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= RESP_OKAY;
      if (S_AXI_ARADDR_I == ADDR_CTRL) begin
        rdata_reg <= ctrl_reg;
      end else if (S_AXI_ARADDR_I == ADDR_STAT) begin
        rdata_reg <= stat_word;
      end else begin
        rdata_reg <= '0;
        rresp_reg <= RESP_SLVERR;
      end
    end else if (rvalid_reg && S_AXI_RREADY_I) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Output wiring, all from flip-flops except IRQ_N_O, which is tied low
  assign S_AXI_AWREADY_O = awready_reg;
  assign S_AXI_WREADY_O  = wready_reg;
  assign S_AXI_BVALID_O  = bvalid_reg;
  assign S_AXI_BRESP_O   = bresp_reg;
  assign S_AXI_ARREADY_O = arready_reg;
  assign S_AXI_RVALID_O  = rvalid_reg;
  assign S_AXI_RDATA_O   = rdata_reg;
  assign S_AXI_RRESP_O   = rresp_reg;
  assign IRQ_N_O         = 1'b0; // Open drain pulls low only
  assign IRQ_N_OE_O      = irq_oe_reg;
  assign BUS_BIT0_O      = b0_o_reg;
  assign BUS_BIT0_OE_O   = b0_oe_reg;
  assign BUS_BIT1_O      = b1_o_reg;
  assign BUS_BIT1_OE_O   = b1_oe_reg;
  assign MODE_PAR_O      = mode_reg[0];
  assign MODE_SER_O      = mode_reg[1];
  assign MODE_HW_O       = mode_reg[2];
  assign HOST_CS_N_O     = cs_n_reg;
  assign HOST_RD_N_O     = rd_n_reg;
  assign HOST_WR_N_O     = wr_n_reg;
  assign HOST_BUS_STYLE_O = bsty_reg;
  assign HOST_AD_O       = ad_reg;
  assign HOST_MOSI_O     = mosi_reg;
  assign JITTER_ATT_CLK_SEL_B0_O = jit_reg;
  assign LINE_CODE_EN_O  = lce_reg;
  assign REMOTE_LOOPBACK_EN_O = rlp_reg;
  assign RX_MODE_SEL_B3_B2_O = rxm_reg;
  assign TX_MODE_SEL_B3_B1_O = txm_reg;
  assign JIT_ATT_EN_O    = jae_reg;
  assign PLL_IN_O        = pll_in_reg;
  assign TX_CLK_O        = ck.tx_clk;
  assign PLL_OUT_O       = ck.tx_clk;

  // Checks
  a_mode_decode: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    {CTRL_MODE_SEL_B1_I, CTRL_MODE_SEL_B0_I} == SEL_SER |=> mode_reg == MODE_SER)
    else $error("serial mode not decoded");
  a_hw_pll_feed: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    mode_reg == MODE_HW |=> pll_in_reg == $past(TX_CLK_IN_I))
    else $error("PLL not fed from transmit clock pin");
  a_pll_out_same: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    mode_reg == MODE_HW && ck.src_sel == TCS_PLL |=> PLL_OUT_O == $past(PLL_CLK_I))
    else $error("PLL output differs from transmit clock");
  a_irq_port_mode: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    mode_reg != MODE_HW |=> irq_oe_reg == $past(IRQ_REQ_I))
    else $error("interrupt drive wrong");
  a_irq_hw_input: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    mode_reg == MODE_HW |=> !irq_oe_reg && jit_reg == $past(IRQ_N_I))
    else $error("jitter select not from pin");
  a_hw_line_code: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    mode_reg == MODE_HW |=> lce_reg == $past(BUS_STYLE_SEL_I) && !bsty_reg)
    else $error("line coding not from pin");
  a_hw_loopback: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    mode_reg == MODE_HW |=> cs_n_reg && rlp_reg == $past(CS_N_I))
    else $error("loopback not from chip select pin");
  a_ser_strobes: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    mode_reg == MODE_SER |=> rd_n_reg && wr_n_reg)
    else $error("strobes active in serial mode");
  a_ser_miso: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    mode_reg == MODE_SER |=> b0_oe_reg == !$past(CS_N_I) && b0_o_reg == $past(SER_MISO_I))
    else $error("serial out drive wrong");
  a_hw_no_drive: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    mode_reg == MODE_HW |=> !b0_oe_reg && !b1_oe_reg)
    else $error("bus pin driven in hardware mode");
  a_hw_tx_mode: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    mode_reg == MODE_HW |=> txm_reg == $past({WR_N_I, TX_MODE_SEL_B2_I, TX_MODE_SEL_B1_I}))
    else $error("transmit mode not from pins");
  a_hw_fixed: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    mode_reg == MODE_HW |=> jae_reg == HW_JIT_ATT_EN)
    else $error("fixed state not forced");
endmodule // cpm_pin_mux

// *** cpm_pin_mux_test.sv ***
// Self-checking bench of the control-mode pin mux: AXI4-Lite tasks plus strap sequences.
// Assumes the board clock model drives the three transmit clock sources.
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin cmp_count++; if ((ac) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, ac); end end
module cpm_pin_mux_test;
  import cpm_pkg::*;
  logic MCLK_I = 0, SRST_I = 1, S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0;
  logic S_AXI_ARVALID_I = 0, S_AXI_RREADY_I = 0, S_AXI_AWREADY_O, S_AXI_WREADY_O;
  logic [7:0] S_AXI_AWADDR_I = 0, S_AXI_ARADDR_I = 0;
  logic [31:0] S_AXI_WDATA_I = 0, S_AXI_RDATA_O, rd;
  logic [3:0] S_AXI_WSTRB_I = 4'hf;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, PAR_AD_DOUT_I = 0, RX_MODE_SEL_B3_B2_O, rsp, s;
  logic S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O, IRQ_N_I, IRQ_N_O, IRQ_N_OE_O;
  logic CTRL_MODE_SEL_B0_I = 0, CTRL_MODE_SEL_B1_I = 0, BUS_STYLE_SEL_I = 0, CS_N_I = 1;
  logic RD_N_I = 1, WR_N_I = 1, BUS_BIT0_I, BUS_BIT0_O, BUS_BIT0_OE_O, BUS_BIT1_I, BUS_BIT1_O;
  logic BUS_BIT1_OE_O, TX_MODE_SEL_B2_I = 0, TX_MODE_SEL_B1_I = 0, TX_CLK_SRC_SEL_B1_I = 0;
  logic IRQ_REQ_I = 0, PAR_AD_OE_I = 0, SER_MISO_I = 0, MODE_PAR_O, MODE_SER_O, MODE_HW_O;
  logic HOST_CS_N_O, HOST_RD_N_O, HOST_WR_N_O, HOST_BUS_STYLE_O, HOST_MOSI_O, JIT_ATT_EN_O;
  logic [1:0] HOST_AD_O;
  logic [2:0] TX_MODE_SEL_B3_B1_O, prv;
  logic JITTER_ATT_CLK_SEL_B0_O, LINE_CODE_EN_O, REMOTE_LOOPBACK_EN_O, TX_CLK_IN_I, PLL_CLK_I;
  logic RX_CLK_I, PLL_IN_O, TX_CLK_O, PLL_OUT_O, irq_drv = 1, b0_drv = 0, b1_drv = 0, last;
  int miscompares = 0, cmp_count = 0, cyc = 0, tog;

  // Open-drain interrupt pulls low; bus bits resolve from both drivers
  assign IRQ_N_I    = IRQ_N_OE_O ? IRQ_N_O : irq_drv;
  assign BUS_BIT0_I = BUS_BIT0_OE_O ? BUS_BIT0_O : b0_drv;
  assign BUS_BIT1_I = BUS_BIT1_OE_O ? BUS_BIT1_O : b1_drv;

  cpm_pin_mux dut (.*);
  cpm_board_clk board (.clk_i(MCLK_I), .srst_i(SRST_I), .tx_clk_o(TX_CLK_IN_I),
                       .pll_clk_o(PLL_CLK_I), .rx_clk_o(RX_CLK_I));

  initial begin
    forever #4 MCLK_I = ~MCLK_I;
  end

  // Source levels seen just before each edge
  always @(posedge MCLK_I) prv <= {RX_CLK_I, PLL_CLK_I, TX_CLK_IN_I};

  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard
  always @(posedge MCLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out;
    end
  end

  task step(input int n);
    repeat (n) @(posedge MCLK_I);
    #1;
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK_I);
    S_AXI_AWADDR_I <= a; S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= 1; S_AXI_WVALID_I <= 1; S_AXI_BREADY_I <= 1;
    forever begin
      @(posedge MCLK_I);
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 0;
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) S_AXI_WVALID_I <= 0;
      if (S_AXI_BVALID_O === 1'b1) begin
        rsp = S_AXI_BRESP_O;
        break;
      end
    end
    S_AXI_BREADY_I <= 0;
    `CHK("bresp", RESP_OKAY, rsp)
  endtask

  task axi_rd(input logic [7:0] a);
    @(posedge MCLK_I);
    S_AXI_ARADDR_I <= a; S_AXI_ARVALID_I <= 1; S_AXI_RREADY_I <= 1;
    forever begin
      @(posedge MCLK_I);
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 0;
      if (S_AXI_RVALID_O === 1'b1) begin
        rd = S_AXI_RDATA_O; rsp = S_AXI_RRESP_O;
        break;
      end
    end
    S_AXI_RREADY_I <= 0;
  endtask

  initial begin
    repeat (5) @(posedge MCLK_I);
    SRST_I <= 0;
    axi_rd(ADDR_CTRL); `CHK("ctrl rst", CTRL_RESET, rd)
    axi_rd(ADDR_STAT); `CHK("mode par", 3'b001, rd[2:0])
    axi_rd(8'h10); `CHK("unmapped", RESP_SLVERR, rsp)
    // Parallel mode: pins act as bus strobes, functions come from CTRL
    @(posedge MCLK_I);
    CS_N_I <= 0; RD_N_I <= 0; BUS_STYLE_SEL_I <= 1; IRQ_REQ_I <= 1; TX_MODE_SEL_B2_I <= 1;
    PAR_AD_DOUT_I <= 2'b10; PAR_AD_OE_I <= 1;
    axi_wr(ADDR_CTRL, 32'h0000_0006); step(3);
    `CHK("par cs", 1'b0, HOST_CS_N_O)
    `CHK("par rd", 1'b0, HOST_RD_N_O)
    `CHK("par wr", 1'b1, HOST_WR_N_O)
    `CHK("par style", 1'b1, HOST_BUS_STYLE_O)
    `CHK("par irq", 1'b1, IRQ_N_OE_O & ~IRQ_N_I)
    `CHK("par ad", 4'b1011, {BUS_BIT1_O, BUS_BIT0_O, BUS_BIT1_OE_O, BUS_BIT0_OE_O})
    `CHK("par host ad", 2'b10, HOST_AD_O)
    `CHK("par mode", 3'b001, {MODE_HW_O, MODE_SER_O, MODE_PAR_O})
    `CHK("par txm", 3'b000, TX_MODE_SEL_B3_B1_O)
    `CHK("par fn", 3'b110, {LINE_CODE_EN_O, REMOTE_LOOPBACK_EN_O, JIT_ATT_EN_O})
    // Serial mode: bit1 carries MOSI, bit0 carries MISO while selected
    @(posedge MCLK_I);
    CTRL_MODE_SEL_B0_I <= 1; SER_MISO_I <= 1; b1_drv <= 1; PAR_AD_OE_I <= 0; step(4);
    `CHK("ser mode", 3'b010, {MODE_HW_O, MODE_SER_O, MODE_PAR_O})
    `CHK("ser mosi", 1'b1, HOST_MOSI_O)
    `CHK("ser miso", 2'b11, {BUS_BIT0_O, BUS_BIT0_OE_O})
    `CHK("ser unused", 3'b110, {HOST_RD_N_O, HOST_WR_N_O, HOST_BUS_STYLE_O})
    // Hardware mode: straps (held stable) drive functions directly
    @(posedge MCLK_I);
    CTRL_MODE_SEL_B0_I <= 0; CTRL_MODE_SEL_B1_I <= 1; BUS_STYLE_SEL_I <= 0;
    RD_N_I <= 1; WR_N_I <= 1; TX_MODE_SEL_B1_I <= 0; IRQ_REQ_I <= 0; step(4);
    `CHK("hw mode", 1'b1, MODE_HW_O)
    `CHK("hw rlb", 1'b0, REMOTE_LOOPBACK_EN_O)
    `CHK("hw hbe", 1'b0, LINE_CODE_EN_O)
    `CHK("hw rxm", 2'b11, RX_MODE_SEL_B3_B2_O)
    `CHK("hw txm", 3'b110, TX_MODE_SEL_B3_B1_O)
    `CHK("hw jit", 2'b10, {JITTER_ATT_CLK_SEL_B0_O, IRQ_N_OE_O})
    `CHK("hw fixed", 1'b1, JIT_ATT_EN_O)
    `CHK("hw host", 4'b1100, {HOST_CS_N_O, HOST_RD_N_O, BUS_BIT0_OE_O, BUS_BIT1_OE_O})
    for (int k = 0; k < 4; k++) begin
      s = k[1:0];
      @(posedge MCLK_I);
      b0_drv <= s[0]; TX_CLK_SRC_SEL_B1_I <= s[1]; step(4);
      axi_rd(ADDR_STAT); `CHK("tcs sel", s, rd[4:3])
      tog = 0; last = TX_CLK_O;
      repeat (20) begin
        @(negedge MCLK_I);
        `CHK("pll out", TX_CLK_O, PLL_OUT_O)
        `CHK("pll in", prv[0], PLL_IN_O)
        if (s == TCS_TXCLK) `CHK("tx pin", prv[0], TX_CLK_O)
        if (s == TCS_PLL) `CHK("tx pll", prv[1], TX_CLK_O)
        if (s == TCS_RXCLK) `CHK("tx rx", prv[2], TX_CLK_O)
        if (TX_CLK_O !== last) tog++;
        last = TX_CLK_O;
      end
      if (s == TCS_MCLK) `CHK("mclk toggles", 20 / (MCLK_DIV_LAST + 1), tog)
    end
    @(posedge MCLK_I);
    CTRL_MODE_SEL_B0_I <= 1; step(4);
    `CHK("hw 11", 1'b1, MODE_HW_O)
    close_out;
  end
endmodule // cpm_pin_mux_test

// *** cpm_pkg.sv ***
// Constants, types and field layout of the control-mode pin multiplexer.
// Assumes one 125 MHz clock; all strap and bus pins arrive synchronous to it.
// Function
// - Hardware mode turns port pins into direct function control inputs.
// - Functions without a pin take fixed states in hardware mode.
// - Two mode select pins choose parallel, serial or hardware; pins follow.
// - Hardware mode always feeds the transmit PLL from the transmit clock pin.
// - Straps pick transmit clock: pin, PLL clock, scaled master, receive clock.
// - PLL clock output equals the selected transmit clock in hardware mode.
// - Interrupt pin: active-low output in port modes, jitter select in hardware.
// - Bus style pin: bus style in parallel, unused serial, line coding hardware.
// - Chip select active low in port modes, remote loopback in hardware.
// - Read pin: read strobe parallel, unused serial, receive mode bit 2 hardware.
// - Write pin: write strobe parallel, unused serial, transmit mode bit 3 hardware.
// - Bus bit 0: data parallel, serial out, transmit clock select bit 0 hardware.
// - Bus bit 1: data parallel, serial in, receive mode bit 3 hardware.
// - Two inputs ignored in port modes give transmit mode bits 2 and 1.
package cpm_pkg;

  // Controller mode, one-hot
  typedef enum logic [2:0] {
    MODE_PAR = 3'b001,
    MODE_SER = 3'b010,
    MODE_HW  = 3'b100
  } cpm_mode_e;

  // Mode select pin decode; any other level is hardware mode
  localparam logic [1:0] SEL_PAR = 2'b00;
  localparam logic [1:0] SEL_SER = 2'b01;

  // Transmit clock source codes {b1,b0}
  localparam logic [1:0] TCS_TXCLK = 2'b00;
  localparam logic [1:0] TCS_PLL   = 2'b01;
  localparam logic [1:0] TCS_MCLK  = 2'b10;
  localparam logic [1:0] TCS_RXCLK = 2'b11;

  // Master clock divider: half period in cycles minus one
  localparam int         DIV_W         = 8;
  localparam logic [7:0] MCLK_DIV_LAST = 8'h03;

  // Register bus
  localparam int         AXI_AW      = 8;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STAT   = 8'h04;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Control register fields
  localparam int          CTRL_JIT    = 0;
  localparam int          CTRL_LCE    = 1;
  localparam int          CTRL_RLP    = 2;
  localparam int          CTRL_RXM    = 3;
  localparam int          CTRL_TXM    = 5;
  localparam int          CTRL_TCS    = 8;
  localparam int          CTRL_JAE    = 10;
  localparam int          CTRL_PSRC   = 11;
  localparam logic [31:0] CTRL_MASK   = 32'h0000_0fff;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0400;

  // Status register fields
  localparam int STAT_MODE = 0;
  localparam int STAT_TCS  = 3;
  localparam int STAT_TXCK = 5;

  // Fixed states forced in hardware mode
  localparam logic HW_JIT_ATT_EN = 1'b1;
  localparam logic HW_PLL_SRC    = 1'b0;

endpackage

// *** cpm_txclk_mux.sv ***
// Registered four-way transmit clock source selector.
// Assumes clocks arrive as levels sampled by the system clock.
`timescale 1ns/1ps
module cpm_txclk_mux (
  input  wire logic clk_i,
  input  wire logic srst_i,
  cpm_clk_if.mux    ck
);
  import cpm_pkg::*;

  logic tx_clk_reg;

  // Pick source by select code
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_clk_reg <= 1'b0;
    end else begin
      case (ck.src_sel)
        TCS_TXCLK: tx_clk_reg <= ck.tx_clk_in;
        TCS_PLL:   tx_clk_reg <= ck.pll_clk;
        TCS_MCLK:  tx_clk_reg <= ck.mclk_scaled;
        TCS_RXCLK: tx_clk_reg <= ck.rx_clk;
        default:   tx_clk_reg <= ck.tx_clk_in;
      endcase
    end
  end

  assign ck.tx_clk = tx_clk_reg;

  a_src_pin: assert property (@(posedge clk_i) disable iff (srst_i)
    ck.src_sel == TCS_TXCLK |=> tx_clk_reg == $past(ck.tx_clk_in))
    else $error("transmit clock not from pin");
  a_src_rx: assert property (@(posedge clk_i) disable iff (srst_i)
    ck.src_sel == TCS_RXCLK |=> tx_clk_reg == $past(ck.rx_clk))
    else $error("transmit clock not from receive clock");
endmodule // cpm_txclk_mux
